// >>> hdl/scr_pkg.sv
package scr_pkg;

    // bus address choice and bit framing
    localparam logic [6:0] SCR_ADDR_STRAP_LOW  = 7'h39;
    localparam logic [6:0] SCR_ADDR_STRAP_HIGH = 7'h3e;
    localparam logic [3:0] SCR_BYTE_BITS       = 4'h8;
    localparam logic [1:0] SCR_STRAP_SETTLE    = 2'h3;
    localparam logic [7:0] SCR_GAP_READ        = 8'hff;
    localparam int         SCR_NREG            = 25;

    // register offsets
    localparam logic [6:0] SCR_OFF_UC_STATUS     = 7'h00;
    localparam logic [6:0] SCR_OFF_UC_SETTINGS   = 7'h01;
    localparam logic [6:0] SCR_OFF_UC_CLOCK      = 7'h02;
    localparam logic [6:0] SCR_OFF_UC_EARLY_HIGH = 7'h03;
    localparam logic [6:0] SCR_OFF_UC_EARLY_LOW  = 7'h04;
    localparam logic [6:0] SCR_OFF_UC_MUTE_HIGH  = 7'h05;
    localparam logic [6:0] SCR_OFF_UC_MUTE_LOW   = 7'h06;
    localparam logic [6:0] SCR_OFF_UC_IO_SLEW    = 7'h07;
    localparam logic [6:0] SCR_OFF_UC_CLOCK_SLEW = 7'h08;
    localparam logic [6:0] SCR_OFF_UC_SYNC_MODE  = 7'h09;
    localparam logic [6:0] SCR_OFF_ANSWER_ONE    = 7'h0a;
    localparam logic [6:0] SCR_OFF_ANSWER_TWO    = 7'h0b;
    localparam logic [6:0] SCR_OFF_ANSWER_THREE  = 7'h0c;
    localparam logic [6:0] SCR_OFF_ANSWER_FOUR   = 7'h0d;
    localparam logic [6:0] SCR_OFF_M1_STATUS     = 7'h10;
    localparam logic [6:0] SCR_OFF_M1_SETTINGS   = 7'h11;
    localparam logic [6:0] SCR_OFF_M1_CLOCK      = 7'h12;
    localparam logic [6:0] SCR_OFF_M1_EARLY_HIGH = 7'h13;
    localparam logic [6:0] SCR_OFF_M1_EARLY_LOW  = 7'h14;
    localparam logic [6:0] SCR_OFF_M1_MUTE_HIGH  = 7'h15;
    localparam logic [6:0] SCR_OFF_M1_MUTE_LOW   = 7'h16;
    localparam logic [6:0] SCR_OFF_MODULE_IO_SLEW    = 7'h17;
    localparam logic [6:0] SCR_OFF_MODULE_CLOCK_SLEW = 7'h18;

    // reset values
    localparam logic [7:0] SCR_RST_ZERO        = 8'h00;
    localparam logic [7:0] SCR_RST_UC_SETTINGS = 8'h60;
    localparam logic [7:0] SCR_RST_M1_SETTINGS = 8'h40;
    localparam logic [7:0] SCR_RST_CLOCK       = 8'h0c;
    localparam logic [7:0] SCR_RST_EARLY_HIGH  = 8'haa;
    localparam logic [7:0] SCR_RST_MUTE_HIGH   = 8'ha4;
    localparam logic [7:0] SCR_RST_MUTE_LOW    = 8'h74;
    localparam logic [7:0] SCR_RST_IO_SLEW     = 8'h80;
    localparam logic [7:0] SCR_RST_CLOCK_SLEW  = 8'ha0;
    localparam logic [7:0] SCR_RST_SYNC_MODE   = 8'h76;

    // status from the card logic, same clock
    typedef struct packed {
        logic [7:0]  uc_status;
        logic [7:0]  m1_status;
        logic        answer_load;
        logic [31:0] answer_bytes;
    } scr_status_s;

    typedef enum logic [8:0] {
        SCR_IDLE      = 9'h001,
        SCR_ADDR      = 9'h002,
        SCR_ACK_ADDR  = 9'h004,
        SCR_REG       = 9'h008,
        SCR_ACK_REG   = 9'h010,
        SCR_WDATA     = 9'h020,
        SCR_ACK_WDATA = 9'h040,
        SCR_RDATA     = 9'h080,
        SCR_RACK      = 9'h100
    } scr_state_e;

    // true for offsets that software may write
    function automatic logic scr_is_rw(input logic [6:0] a);
        return (a >= SCR_OFF_UC_SETTINGS && a <= SCR_OFF_UC_SYNC_MODE) ||
               (a >= SCR_OFF_M1_SETTINGS && a <= SCR_OFF_MODULE_CLOCK_SLEW);
    endfunction : scr_is_rw

    // reset value of the writable store at an offset
    function automatic logic [7:0] scr_reset_val(input logic [6:0] a);
        case (a)
            SCR_OFF_UC_SETTINGS:                  return SCR_RST_UC_SETTINGS;
            SCR_OFF_M1_SETTINGS:                  return SCR_RST_M1_SETTINGS;
            SCR_OFF_UC_CLOCK, SCR_OFF_M1_CLOCK:   return SCR_RST_CLOCK;
            SCR_OFF_UC_EARLY_HIGH, SCR_OFF_M1_EARLY_HIGH: return SCR_RST_EARLY_HIGH;
            SCR_OFF_UC_MUTE_HIGH, SCR_OFF_M1_MUTE_HIGH:   return SCR_RST_MUTE_HIGH;
            SCR_OFF_UC_MUTE_LOW, SCR_OFF_M1_MUTE_LOW:     return SCR_RST_MUTE_LOW;
            SCR_OFF_UC_IO_SLEW, SCR_OFF_MODULE_IO_SLEW:   return SCR_RST_IO_SLEW;
            SCR_OFF_UC_CLOCK_SLEW, SCR_OFF_MODULE_CLOCK_SLEW: return SCR_RST_CLOCK_SLEW;
            SCR_OFF_UC_SYNC_MODE:                 return SCR_RST_SYNC_MODE;
            default:                              return SCR_RST_ZERO;
        endcase
    endfunction : scr_reset_val

endpackage : scr_pkg

// >>> hdl/scr_regmap.sv
`timescale 1ns/1ps
module scr_regmap
    import scr_pkg::*;
(
    input  wire logic                       clk,
    input  wire logic                       reset_n,
    input  wire logic                       scl_in,
    input  wire logic                       sda_in,
    output logic                            sda_out,
    output logic                            sda_oe,
    input  wire logic                       address_strap_pin,
    input  wire scr_status_s                status_in,
    output logic [SCR_NREG-1:0][7:0]        register_bank,
    output logic [31:0]                     captured_answer
);

    ////////////////////////////////////////////////////////////////////////
    logic       scl_s1, scl_s2, scl_s3;
    logic       sda_s1, sda_s2, sda_s3;
    logic       strap_s1, strap_s2;
    logic       strap_reg, strap_next;
    logic [1:0] settle_reg, settle_next;
    logic       scl_rise, scl_fall, bus_start, bus_stop;
    logic [6:0] own_addr;

    // pin synchronisers, pure two-stage plus history for edges
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            {scl_s1, scl_s2, scl_s3} <= 3'h7;
            {sda_s1, sda_s2, sda_s3} <= 3'h7;
            {strap_s1, strap_s2}     <= 2'h0;
        end else begin
            {scl_s1, scl_s2, scl_s3} <= {scl_in, scl_s1, scl_s2};
            {sda_s1, sda_s2, sda_s3} <= {sda_in, sda_s1, sda_s2};
            {strap_s1, strap_s2}     <= {address_strap_pin, strap_s1};
        end
    end

    // bus events from the synchronised lines
    assign scl_rise  = scl_s2 & ~scl_s3;
    assign scl_fall  = ~scl_s2 & scl_s3;
    assign bus_start = scl_s2 & scl_s3 & sda_s3 & ~sda_s2;
    assign bus_stop  = scl_s2 & scl_s3 & ~sda_s3 & sda_s2;

    // strap caught once the synchroniser has settled after reset
    always_comb begin
        strap_next  = strap_reg;
        settle_next = settle_reg;
        if (settle_reg != SCR_STRAP_SETTLE) begin
            settle_next = settle_reg + 2'h1;
            strap_next  = strap_s2;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            strap_reg  <= 1'b0;
            settle_reg <= 2'h0;
        end else begin
            strap_reg  <= strap_next;
            settle_reg <= settle_next;
        end
    end

    assign own_addr = strap_reg ? SCR_ADDR_STRAP_HIGH : SCR_ADDR_STRAP_LOW;

    ////////////////////////////////////////////////////////////////////////
    scr_state_e               state_reg, state_next;
    logic [3:0]               cnt_reg, cnt_next;
    logic [7:0]               shift_reg, shift_next;
    logic [7:0]               tx_reg, tx_next;
    logic [6:0]               ptr_reg, ptr_next;
    logic                     ai_reg, ai_next;
    logic                     dir_reg, dir_next;
    logic                     first_reg, first_next;
    logic                     oe_next;
    logic                     wr_en;
    logic [SCR_NREG-1:0][7:0] bank_next;
    logic [31:0]              answer_next;

    // read data for an offset; gaps give the fill pattern
    function automatic logic [7:0] rd_byte(input logic [6:0] a, input logic [SCR_NREG-1:0][7:0] bank,
                                           input logic [31:0] ans, input scr_status_s st);
        if (a == SCR_OFF_UC_STATUS) begin
            return st.uc_status;
        end else if (a == SCR_OFF_M1_STATUS) begin
            return st.m1_status;
        end else if (a == SCR_OFF_ANSWER_ONE) begin
            return ans[7:0];
        end else if (a == SCR_OFF_ANSWER_TWO) begin
            return ans[15:8];
        end else if (a == SCR_OFF_ANSWER_THREE) begin
            return ans[23:16];
        end else if (a == SCR_OFF_ANSWER_FOUR) begin
            return ans[31:24];
        end else if (scr_is_rw(a)) begin
            return bank[a[4:0]];
        end else begin
            return SCR_GAP_READ;
        end
    endfunction : rd_byte

    // slave sequencer and register store
    always_comb begin
        state_next  = state_reg;
        cnt_next    = cnt_reg;
        shift_next  = shift_reg;
        tx_next     = tx_reg;
        ptr_next    = ptr_reg;
        ai_next     = ai_reg;
        dir_next    = dir_reg;
        first_next  = first_reg;
        oe_next     = sda_oe;
        bank_next   = register_bank;
        answer_next = captured_answer;
        wr_en       = 1'b0;
        if (status_in.answer_load) begin
            answer_next = status_in.answer_bytes;
        end
        if (scl_rise) begin
            shift_next = {shift_reg[6:0], sda_s2};
            cnt_next   = cnt_reg + 4'h1;
        end
        if (bus_start) begin
            state_next = SCR_ADDR;
            cnt_next   = 4'h0;
            oe_next    = 1'b0;
        end else if (bus_stop) begin
            state_next = SCR_IDLE;
            oe_next    = 1'b0;
        end else begin
            case (state_reg)
                SCR_ADDR: begin
                    if (scl_fall && cnt_reg == SCR_BYTE_BITS) begin
                        if (shift_reg[7:1] == own_addr) begin
                            dir_next   = shift_reg[0];
                            oe_next    = 1'b1;
                            state_next = SCR_ACK_ADDR;
                        end else begin
                            state_next = SCR_IDLE;
                        end
                    end
                end
                SCR_ACK_ADDR: begin
                    if (scl_fall) begin
                        cnt_next = 4'h0;
                        if (dir_reg) begin
                            tx_next    = rd_byte(ptr_reg, register_bank, captured_answer, status_in);
                            oe_next    = ~tx_next[7];
                            state_next = SCR_RDATA;
                        end else begin
                            oe_next    = 1'b0;
                            state_next = SCR_REG;
                        end
                    end
                end
                SCR_REG: begin
                    if (scl_fall && cnt_reg == SCR_BYTE_BITS) begin
                        ptr_next   = shift_reg[6:0];
                        ai_next    = shift_reg[7];
                        first_next = 1'b1;
                        oe_next    = 1'b1;
                        state_next = SCR_ACK_REG;
                    end
                end
                SCR_ACK_REG, SCR_ACK_WDATA: begin
                    if (scl_fall) begin
                        oe_next    = 1'b0;
                        cnt_next   = 4'h0;
                        state_next = SCR_WDATA;
                    end
                end
                SCR_WDATA: begin
                    if (scl_fall && cnt_reg == SCR_BYTE_BITS) begin
                        wr_en      = first_reg | ai_reg;
                        ptr_next   = ai_reg ? ptr_reg + 7'h1 : ptr_reg;
                        first_next = 1'b0;
                        oe_next    = 1'b1;
                        state_next = SCR_ACK_WDATA;
                    end
                end
                SCR_RDATA: begin
                    if (scl_fall) begin
                        if (cnt_reg == SCR_BYTE_BITS) begin
                            oe_next    = 1'b0;
                            state_next = SCR_RACK;
                        end else begin
                            tx_next = {tx_reg[6:0], 1'b0};
                            oe_next = ~tx_reg[6];
                        end
                    end
                end
                SCR_RACK: begin
                    if (scl_rise) begin
                        if (sda_s2) begin
                            state_next = SCR_IDLE;
                        end else if (ai_reg) begin
                            ptr_next = ptr_reg + 7'h1;
                        end
                    end else if (scl_fall) begin
                        cnt_next   = 4'h0;
                        tx_next    = rd_byte(ptr_reg, register_bank, captured_answer, status_in);
                        oe_next    = ~tx_next[7];
                        state_next = SCR_RDATA;
                    end
                end
                default: begin
                    oe_next = 1'b0;
                end
            endcase
        end
        for (int i = 0; i < SCR_NREG; i++) begin
            if (wr_en && ptr_reg == 7'(i) && scr_is_rw(7'(i))) begin
                bank_next[i] = shift_reg;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            state_reg       <= SCR_IDLE;
            cnt_reg         <= 4'h0;
            shift_reg       <= 8'h00;
            tx_reg          <= 8'h00;
            ptr_reg         <= 7'h00;
            ai_reg          <= 1'b0;
            dir_reg         <= 1'b0;
            first_reg       <= 1'b0;
            sda_oe          <= 1'b0;
            sda_out         <= 1'b0;
            captured_answer <= 32'h0000_0000;
            for (int i = 0; i < SCR_NREG; i++) begin
                register_bank[i] <= scr_reset_val(7'(i));
            end
        end else begin
            state_reg       <= state_next;
            cnt_reg         <= cnt_next;
            shift_reg       <= shift_next;
            tx_reg          <= tx_next;
            ptr_reg         <= ptr_next;
            ai_reg          <= ai_next;
            dir_reg         <= dir_next;
            first_reg       <= first_next;
            sda_oe          <= oe_next;
            sda_out         <= 1'b0;
            captured_answer <= answer_next;
            register_bank   <= bank_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    logic addr_end;
    assign addr_end = state_reg == SCR_ADDR && scl_fall && cnt_reg == SCR_BYTE_BITS && !bus_start && !bus_stop;

    strap_low_ack_a: assert property (addr_end && !strap_reg && shift_reg[7:1] == 7'h39 |=>
        sda_oe && state_reg == SCR_ACK_ADDR) else $error("low strap address not acked");
    strap_high_ack_a: assert property (addr_end && strap_reg && shift_reg[7:1] == 7'h3e |=>
        sda_oe && state_reg == SCR_ACK_ADDR) else $error("high strap address not acked");
    foreign_addr_a: assert property (addr_end && shift_reg[7:1] != own_addr |=>
        !sda_oe && state_reg == SCR_IDLE) else $error("foreign address acked");
    read_dir_a: assert property (state_reg == SCR_ACK_ADDR && scl_fall && dir_reg && !bus_start && !bus_stop
        |=> state_reg == SCR_RDATA) else $error("read bit did not start read");
    reg_ack_a: assert property (state_reg == SCR_REG && scl_fall && cnt_reg == SCR_BYTE_BITS
        && !bus_start && !bus_stop |=> sda_oe && ptr_reg == $past(shift_reg[6:0])) else $error("pointer not acked");
    ai_step_a: assert property (state_reg == SCR_WDATA && scl_fall && cnt_reg == SCR_BYTE_BITS && ai_reg
        && !bus_start && !bus_stop |=> ptr_reg == 7'($past(ptr_reg) + 7'h1)) else $error("pointer not stepped");
    no_ai_hold_a: assert property (state_reg == SCR_WDATA && !ai_reg && !first_reg
        |=> register_bank == $past(register_bank)) else $error("ignored byte was written");
    gap_read_a: assert property (state_reg == SCR_ACK_ADDR && scl_fall && dir_reg && ptr_reg == 7'h7f
        && !bus_start && !bus_stop |=> tx_reg == 8'hff) else $error("gap read not 0xff");
    answer_hold_a: assert property (!status_in.answer_load |=> captured_answer == $past(captured_answer))
        else $error("answer bytes changed without capture");
    ro_slot_a: assert property (register_bank[SCR_OFF_UC_STATUS[4:0]] == 8'h00
        && register_bank[SCR_OFF_ANSWER_ONE[4:0]] == 8'h00) else $error("read-only slot written");
    slew_reset_a: assert property ($past(!reset_n) |-> register_bank[23] == 8'h80
        && register_bank[24] == 8'ha0 && register_bank[9] == 8'h76) else $error("reset value wrong");

    ai_write_c: cover property (state_reg == SCR_ACK_WDATA && ai_reg && !first_reg);
    ai_read_c: cover property (state_reg == SCR_RACK && scl_rise && !sda_s2 && ai_reg);
    nack_c: cover property (state_reg == SCR_RACK && scl_rise && sda_s2);
    gap_c: cover property (state_reg == SCR_RDATA && tx_reg == 8'hff);

endmodule : scr_regmap

// >>> test/scr_i2c_master.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// bus master model: open-drain data, master-driven bus clock
module scr_i2c_master (
    input  wire logic clk,
    input  wire logic sda_line,
    output logic      scl,
    output logic      sda_pull
);
    // bus idles with both lines released
    initial begin
        scl = 1'b1;
        sda_pull = 1'b0;
    end

    // wait a number of system clocks
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask : tick

    // one bit slot: low 10 clk, high 10 clk, line sampled mid high phase
    task automatic bit_io(input logic b, output logic r);
        sda_pull <= ~b;
        tick(6);
        scl <= 1'b1;
        tick(5);
        @(negedge clk) r = sda_line;
        tick(5);
        scl <= 1'b0;
        tick(4);
    endtask : bit_io

    // start, or repeated start when the clock is low
    task automatic start();
        if (scl == 1'b0) begin
            sda_pull <= 1'b0;
            tick(6);
            scl <= 1'b1;
            tick(10);
        end
        sda_pull <= 1'b1;
        tick(10);
        scl <= 1'b0;
        tick(4);
    endtask : start

    // stop: data rises while the clock is high
    task automatic stop();
        sda_pull <= 1'b1;
        tick(6);
        scl <= 1'b1;
        tick(10);
        sda_pull <= 1'b0;
        tick(10);
    endtask : stop

    // send a byte msb first, data released for the acknowledge slot
    task automatic put_byte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(d[i], r);
        bit_io(1'b1, r);
        ack = ~r;
    endtask : put_byte

    // receive a byte msb first, then acknowledge or not
    task automatic get_byte(input logic ack, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, r);
            d[i] = r;
        end
        bit_io(~ack, r);
    endtask : get_byte
endmodule : scr_i2c_master

// >>> test/scr_regmap_tb.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
module scr_regmap_tb;
    import scr_pkg::*;
    logic                     clk      = 1'b0;
    logic                     reset_n  = 1'b0;
    logic                     strap    = 1'b0;
    scr_status_s              status   = {8'h3c, 8'hc3, 1'b0, 32'h0};
    logic [6:0]               dev_addr = SCR_ADDR_STRAP_LOW;
    logic                     sda_oe;
    logic                     sda_out;
    logic                     scl;
    logic                     m_pull;
    logic                     sda_wire;
    logic                     ack;
    logic [SCR_NREG-1:0][7:0] bank;
    logic [31:0]              answer;
    logic [7:0]               eq[$];
    int                       failures    = 0;
    int                       checks_done = 0;
    logic [7:0] rst_tab [25] = '{8'h00, 8'h60, 8'h0c, 8'haa, 8'h00, 8'ha4, 8'h74, 8'h80, 8'ha0, 8'h76,
        8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 8'hff, 8'h00, 8'h40, 8'h0c, 8'haa, 8'h00, 8'ha4, 8'h74,
        8'h80, 8'ha0};

    always #12.5 clk = ~clk;
    // open-drain data line with pull-up
    assign sda_wire = ~(sda_oe | m_pull);

    scr_regmap dut (.clk(clk), .reset_n(reset_n), .scl_in(scl), .sda_in(sda_wire), .sda_out(sda_out),
        .sda_oe(sda_oe), .address_strap_pin(strap), .status_in(status), .register_bank(bank),
        .captured_answer(answer));
    scr_i2c_master m (.clk(clk), .sda_line(sda_wire), .scl(scl), .sda_pull(m_pull));

    // compare data values
    task automatic check_data(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("BAD at %0t got %h expected %h", $time, got, exp);
        end
    endtask : check_data

    // compare acknowledge levels
    task automatic check_ack(input logic got, input logic exp);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("BAD at %0t got %h expected %h", $time, got, exp);
        end
    endtask : check_ack

    // counts and verdict, ends the run
    task automatic final_report();
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : final_report

    task automatic do_reset(input logic s);
        strap <= s;
        reset_n <= 1'b0;
        repeat (5) @(posedge clk);
        reset_n <= 1'b1;
        repeat (6) @(posedge clk);
    endtask : do_reset

    // address byte with write bit, then pointer byte
    task automatic address(input logic [7:0] ptr);
        m.start();
        m.put_byte({dev_addr, 1'b0}, ack);
        check_ack(ack, 1'b1);
        m.put_byte(ptr, ack);
        check_ack(ack, 1'b1);
        check_ack(sda_out, 1'b0);
    endtask : address

    task automatic wr_seq(input logic [7:0] ptr, input logic [7:0] d[$]);
        address(ptr);
        foreach (d[i]) begin
            m.put_byte(d[i], ack);
            check_ack(ack, 1'b1);
        end
        m.stop();
    endtask : wr_seq

    // repeated start, read bit set, last byte not acknowledged
    task automatic rd_seq(input logic [7:0] ptr, input logic [7:0] e[$]);
        logic [7:0] got;
        address(ptr);
        m.start();
        m.put_byte({dev_addr, 1'b1}, ack);
        check_ack(ack, 1'b1);
        foreach (e[i]) begin
            m.get_byte(i != e.size() - 1, got);
            check_data(got, e[i]);
        end
        m.stop();
    endtask : rd_seq

    // test sequence
    initial begin
        do_reset(1'b0);
        for (int i = 0; i < SCR_NREG; i++) check_data(bank[i], (rst_tab[i] == 8'hff) ? 8'h00 : rst_tab[i]);
        for (int i = 0; i < SCR_NREG; i++) eq.push_back(rst_tab[i]);
        eq[0] = 8'h3c;
        eq[16] = 8'hc3;
        rd_seq(8'h80, eq);
        $display("test reset_map done");
        status.answer_bytes <= 32'h44332211;
        status.answer_load <= 1'b1;
        @(posedge clk);
        status.answer_load <= 1'b0;
        @(posedge clk);
        check_data(answer, 32'h44332211);
        wr_seq(8'h8a, '{8'ha1, 8'ha2, 8'ha3, 8'ha4, 8'ha5, 8'ha6, 8'ha7, 8'ha8});
        check_data(answer, 32'h44332211);
        for (int i = 10; i < 17; i++) check_data(bank[i], 8'h00);
        check_data(bank[17], 8'ha8);
        rd_seq(8'h8a, '{8'h11, 8'h22, 8'h33, 8'h44, 8'hff, 8'hff, 8'hc3, 8'ha8});
        $display("test read_only done");
        wr_seq(8'h17, '{8'h55, 8'h66});
        check_data(bank[23], 8'h55);
        check_data(bank[24], 8'ha0);
        rd_seq(8'h17, '{8'h55, 8'h55});
        wr_seq(8'h88, '{8'h5a, 8'h0f});
        check_data(bank[8], 8'h5a);
        check_data(bank[9], 8'h0f);
        $display("test increment done");
        m.start();
        m.put_byte({SCR_ADDR_STRAP_HIGH, 1'b0}, ack);
        check_ack(ack, 1'b0);
        m.stop();
        wr_seq(8'h7f, '{8'h12});
        rd_seq(8'h7f, '{8'hff});
        $display("test addressing done");
        do_reset(1'b1);
        check_data(answer, 32'h0000_0000);
        dev_addr = SCR_ADDR_STRAP_HIGH;
        rd_seq(8'h88, '{8'ha0, 8'h76});
        check_data(bank[23], 8'h80);
        m.start();
        m.put_byte({SCR_ADDR_STRAP_LOW, 1'b0}, ack);
        check_ack(ack, 1'b0);
        m.stop();
        $display("test strap_high done");
        final_report();
    end

    // hang guard, well beyond the expected 15000 clocks
    initial begin
        repeat (60000) @(posedge clk);
        failures++;
        final_report();
    end
endmodule : scr_regmap_tb
